// File: sar_adc_pkg.sv
package sar_adc_pkg;

   // Register byte offsets
   localparam logic [7:0] CTRL_OFF   = 8'h00;  // converter_control
   localparam logic [7:0] RESULT_OFF = 8'h04;  // conversion_result
   localparam logic [7:0] FLAG_OFF   = 8'h08;  // conversion_flag in bit 0
   localparam logic [7:0] IRQEN_OFF  = 8'h0C;  // conversion_irq_enable in bit 0

   // converter_control field positions
   localparam int CLK_SEL_LSB = 5;  // conv_clock_select [7:5]
   localparam int IN_SEL_LSB  = 2;  // input_select [4:2]
   localparam int BUSY_BIT    = 1;  // busy / start
   localparam int ON_BIT      = 0;  // converter_on

   // Reset values
   localparam logic [7:0] CTRL_RST   = 8'h00;
   localparam logic [7:0] RESULT_RST = 8'h00;

   // Input select codes
   localparam logic [2:0] CH_PIN2 = 3'h2;  // Highest analog pin code
   localparam logic [2:0] CH_TEMP = 3'h6;  // Temperature indicator
   localparam logic [2:0] CH_FREF = 3'h7;  // Fixed reference buffer

   // Clock select: low two bits both set picks the RC clock
   localparam logic [1:0] CLK_RC_LOW = 2'h3;

   // Conversion timing in half bit periods, RC start delay in core clocks
   localparam logic [4:0] HALF_TOTAL = 5'h13;  // 9.5 bit periods
   localparam logic [4:0] HALF_FIRST = 5'h05;  // First bit decided here
   localparam logic [1:0] INSTR_CYC  = 2'h3;   // 4 core clocks, minus one

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Sequencer states
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_DELAY = 3'b010,
      ST_CONV  = 3'b100
   } state_type;

endpackage

// File: bit_period_gen.sv
`timescale 1ns/100ps
module bit_period_gen #(
   parameter int CNT_W = 5  // Half-period counter width
) (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       reset_n,
   // Control
   input  wire logic       run,
   input  wire logic [2:0] clk_sel,
   input  wire logic       rc_clock,
   // Half bit period strobe
   output logic            half_tick
);

   // Divide by 64 needs a five-bit half-period counter
   if (CNT_W < 5) begin : g_cnt_w_check
      $error("CNT_W too small for divide by 64");
   end

   logic [CNT_W-1:0] cnt_q;     // Core clocks within a half period
   logic [CNT_W-1:0] cnt_d;
   logic             rc_prev_q; // Last RC clock level
   logic [CNT_W-1:0] last_cnt;  // Terminal count of the divider
   logic             use_rc;    // RC clock selected

   // Divider terminal count and half-period strobe
   always_comb begin
      use_rc   = (clk_sel[1:0] == sar_adc_pkg::CLK_RC_LOW);
      // Half period is 2^{sel[1:0],sel[2]} core clocks
      last_cnt = CNT_W'((32'h1 << {clk_sel[1:0], clk_sel[2]}) - 32'h1);
      cnt_d    = cnt_q;
      if (!run) begin
         cnt_d     = '0;
         half_tick = 1'b0;
      end else if (use_rc) begin
         // Each RC edge marks half a bit period
         half_tick = (rc_clock != rc_prev_q);
      end else begin
         half_tick = (cnt_q == last_cnt);
         cnt_d     = half_tick ? '0 : cnt_q + CNT_W'(1);
      end
   end

   // Register stage
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q     <= '0;
         rc_prev_q <= 1'b0;
      end else begin
         cnt_q     <= cnt_d;
         rc_prev_q <= rc_clock;
      end
   end

   div2_tick_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      (run && clk_sel == 3'b000) [*2] |-> half_tick)
      else $error("divide by two must tick every core clock");

endmodule // bit_period_gen

// File: sar_adc_sequencer.sv
// Operation
// - Eight-bit successive approximation result into result register
// - Input select picks one of five sources
// - Reference is always the supply voltage
// - Clock select gives divider ratio or RC clock
// - Conversion lasts nine and a half bit periods
// - Start only while converter is on
// - Completion clears busy, sets flag, loads result
// - Flag set regardless of interrupt enable
// - Only software clears the conversion flag
// - Enabled interrupt raised awake and asleep, wakes
// - Busy cleared mid-conversion stores filled partial result
// - Reset clears registers, stops converter and conversion
// - RC clock delays start by one instruction
// - Sleep aborts non-RC conversions, powers down converter
// - Sleep, interrupt off: power down after completion
// - Abort sets no flag; busy reads zero when off
// - Input select code map with reserved codes
`timescale 1ns/100ps
module sar_adc_sequencer (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   // AXI4-Lite write address and data
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   // AXI4-Lite write response
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   // AXI4-Lite read
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [7:0]  s_axi_araddr,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   // Device state
   input  wire logic        sleep_mode,
   input  wire logic        dedicated_rc_clock,
   // Analog side
   output logic [2:0]       channel_select,
   output logic             channel_connected,
   output logic             sample_hold,
   output logic [7:0]       dac_code,
   input  wire logic        comparator_high,
   output logic             converter_powered,
   // Interrupt request and wake
   output logic             conversion_irq,
   output logic             wake_request
);

   // AXI state
   logic        aw_full_q, aw_full_d;   // Write address held
   logic [7:0]  awaddr_q, awaddr_d;     // Held write address
   logic        w_full_q, w_full_d;     // Write data held
   logic [31:0] wdata_q, wdata_d;       // Held write data
   logic        wstrb0_q, wstrb0_d;     // Low byte lane enabled
   logic        bvalid_q, bvalid_d;     // Write response pending
   logic [1:0]  bresp_q, bresp_d;
   logic        rvalid_q, rvalid_d;     // Read data pending
   logic [31:0] rdata_q, rdata_d;
   logic [1:0]  rresp_q, rresp_d;
   logic        do_write;               // Both halves present
   logic        write_hit;              // Write maps to a register

   // Converter state
   sar_adc_pkg::state_type state_q, state_d;
   logic [2:0]  clk_sel_q, clk_sel_d;   // conv_clock_select
   logic [2:0]  in_sel_q, in_sel_d;     // input_select
   logic        on_q, on_d;             // converter_on
   logic        busy_q, busy_d;         // busy / start
   logic [7:0]  result_q, result_d;     // conversion_result
   logic        flag_q, flag_d;         // conversion_flag
   logic        irq_en_q, irq_en_d;     // conversion_irq_enable
   logic [7:0]  sar_q, sar_d;           // Decided bits
   logic [7:0]  mask_q, mask_d;         // Which bits are decided
   logic        last_q, last_d;         // Last decided bit value
   logic [2:0]  bit_ptr_q, bit_ptr_d;   // Bit under trial
   logic [4:0]  half_cnt_q, half_cnt_d; // Half bit periods elapsed
   logic [1:0]  dly_q, dly_d;           // RC start delay count
   logic [7:0]  dac_q, dac_d;
   logic        conn_q, conn_d;
   logic        power_q, power_d;
   logic        irq_q, irq_d;
   logic        wake_q, wake_d;

   // Helpers
   logic        half_tick;              // Half bit period strobe
   logic        use_rc;                 // RC clock selected
   logic [4:0]  half_next;              // Half count after this tick
   logic        decide;                 // A bit is decided now
   logic        complete;               // Normal completion now
   logic        sw_abort;               // Busy cleared mid-conversion
   logic [7:0]  new_ctrl;               // Written control byte
   logic [7:0]  final_code;             // Result at completion

   assign use_rc = (clk_sel_q[1:0] == sar_adc_pkg::CLK_RC_LOW);

   // Bit period timing source
   bit_period_gen #(.CNT_W(5)) u_bit_period (
      .core_clk  (core_clk),
      .reset_n   (reset_n),
      .run       (state_q == sar_adc_pkg::ST_CONV),
      .clk_sel   (clk_sel_q),
      .rc_clock  (dedicated_rc_clock),
      .half_tick (half_tick)
   );

   // Handshakes straight from held state
   assign s_axi_awready = !aw_full_q && !bvalid_q;
   assign s_axi_wready  = !w_full_q && !bvalid_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   // AXI slave: capture halves in any order, answer reads in one cycle
   always_comb begin
      aw_full_d = aw_full_q;
      awaddr_d  = awaddr_q;
      w_full_d  = w_full_q;
      wdata_d   = wdata_q;
      wstrb0_d  = wstrb0_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      rvalid_d  = rvalid_q;
      rdata_d   = rdata_q;
      rresp_d   = rresp_q;
      do_write  = aw_full_q && w_full_q;
      // Address decode of the held write
      if (awaddr_q == sar_adc_pkg::CTRL_OFF) begin
         write_hit = 1'b1;
      end else if (awaddr_q == sar_adc_pkg::RESULT_OFF) begin
         write_hit = 1'b1;
      end else if (awaddr_q == sar_adc_pkg::FLAG_OFF) begin
         write_hit = 1'b1;
      end else if (awaddr_q == sar_adc_pkg::IRQEN_OFF) begin
         write_hit = 1'b1;
      end else begin
         write_hit = 1'b0;
      end
      if (s_axi_awvalid && s_axi_awready) begin
         aw_full_d = 1'b1;
         awaddr_d  = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_full_d = 1'b1;
         wdata_d  = s_axi_wdata;
         wstrb0_d = s_axi_wstrb[0];
      end
      // Response follows both halves
      if (do_write) begin
         aw_full_d = 1'b0;
         w_full_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = write_hit ? sar_adc_pkg::RESP_OKAY : sar_adc_pkg::RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
      // Read decode, narrow data in low bits
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_d = 1'b1;
         rresp_d  = sar_adc_pkg::RESP_OKAY;
         if (s_axi_araddr == sar_adc_pkg::CTRL_OFF) begin
            rdata_d = {24'h000000, clk_sel_q, in_sel_q, busy_q, on_q};
         end else if (s_axi_araddr == sar_adc_pkg::RESULT_OFF) begin
            rdata_d = {24'h000000, result_q};
         end else if (s_axi_araddr == sar_adc_pkg::FLAG_OFF) begin
            rdata_d = {31'h00000000, flag_q};
         end else if (s_axi_araddr == sar_adc_pkg::IRQEN_OFF) begin
            rdata_d = {31'h00000000, irq_en_q};
         end else begin
            rdata_d = 32'h00000000;
            rresp_d = sar_adc_pkg::RESP_SLVERR;
         end
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
   end

   // Converter registers and successive approximation sequencer
   always_comb begin
      state_d    = state_q;
      clk_sel_d  = clk_sel_q;
      in_sel_d   = in_sel_q;
      on_d       = on_q;
      busy_d     = busy_q;
      result_d   = result_q;
      flag_d     = flag_q;
      irq_en_d   = irq_en_q;
      sar_d      = sar_q;
      mask_d     = mask_q;
      last_d     = last_q;
      bit_ptr_d  = bit_ptr_q;
      half_cnt_d = half_cnt_q;
      dly_d      = dly_q;
      half_next  = half_cnt_q + 5'h01;
      decide     = 1'b0;
      complete   = 1'b0;
      sw_abort   = 1'b0;
      new_ctrl   = wdata_q[7:0];
      final_code = sar_q | (comparator_high ? (8'h01 << bit_ptr_q) : 8'h00);

      // Hardware progress of the conversion
      case (state_q)
         sar_adc_pkg::ST_DELAY: begin
            // One instruction cycle before an RC conversion starts
            dly_d = dly_q + 2'h1;
            if (dly_q == sar_adc_pkg::INSTR_CYC) begin
               state_d = sar_adc_pkg::ST_CONV;
            end
         end
         sar_adc_pkg::ST_CONV: begin
            if (half_tick) begin
               half_cnt_d = half_next;
               // One decision per bit period after the first two
               decide = (half_next >= sar_adc_pkg::HALF_FIRST) && half_next[0];
            end
            if (decide) begin
               // Compare supply-scaled trial code, MSB first
               sar_d     = final_code;
               mask_d    = mask_q | (8'h01 << bit_ptr_q);
               last_d    = comparator_high;
               bit_ptr_d = bit_ptr_q - 3'h1;
            end
            if (decide && half_next == sar_adc_pkg::HALF_TOTAL) begin
               // Normal end after 9.5 bit periods
               complete = 1'b1;
               result_d = final_code;
               busy_d   = 1'b0;
               state_d  = sar_adc_pkg::ST_IDLE;
            end
         end
         default: begin
            dly_d = 2'h0;
         end
      endcase

      // Software writes, low byte lane only
      if (do_write && wstrb0_q) begin
         if (awaddr_q == sar_adc_pkg::CTRL_OFF) begin
            clk_sel_d = new_ctrl[sar_adc_pkg::CLK_SEL_LSB +: 3];
            in_sel_d  = new_ctrl[sar_adc_pkg::IN_SEL_LSB +: 3];
            on_d      = new_ctrl[sar_adc_pkg::ON_BIT];
            if (!new_ctrl[sar_adc_pkg::ON_BIT]) begin
               // Off: abandon conversion, busy reads zero
               busy_d  = 1'b0;
               state_d = sar_adc_pkg::ST_IDLE;
            end else if (new_ctrl[sar_adc_pkg::BUSY_BIT]) begin
               // Start only if already on before this write
               if (on_q && state_q == sar_adc_pkg::ST_IDLE && !complete) begin
                  busy_d     = 1'b1;
                  sar_d      = 8'h00;
                  mask_d     = 8'h00;
                  last_d     = 1'b0;
                  bit_ptr_d  = 3'h7;
                  half_cnt_d = 5'h00;
                  dly_d      = 2'h0;
                  state_d    = (new_ctrl[6:5] == sar_adc_pkg::CLK_RC_LOW) ?
                               sar_adc_pkg::ST_DELAY : sar_adc_pkg::ST_CONV;
               end
            end else if (busy_q && !complete) begin
               // Abort: fill undecided bits with the last decision
               sw_abort = 1'b1;
               busy_d   = 1'b0;
               state_d  = sar_adc_pkg::ST_IDLE;
               result_d = (sar_q & mask_q) | (last_q ? ~mask_q : 8'h00);
            end
         end else if (awaddr_q == sar_adc_pkg::RESULT_OFF) begin
            result_d = new_ctrl;
         end else if (awaddr_q == sar_adc_pkg::FLAG_OFF) begin
            flag_d = new_ctrl[0];
         end else if (awaddr_q == sar_adc_pkg::IRQEN_OFF) begin
            irq_en_d = new_ctrl[0];
         end
      end

      // Sleep without the RC clock kills the conversion, keeps on bit
      if (sleep_mode && !use_rc && state_q != sar_adc_pkg::ST_IDLE) begin
         busy_d  = 1'b0;
         state_d = sar_adc_pkg::ST_IDLE;
      end

      // Completion sets the flag over a same-cycle clear
      if (complete) begin
         flag_d = 1'b1;
      end

      // Trial code presented to the comparator
      dac_d = (state_d == sar_adc_pkg::ST_CONV) ? (sar_d | (8'h01 << bit_ptr_d)) : sar_d;
      // Codes 3 to 5 connect nothing
      conn_d = (in_sel_d <= sar_adc_pkg::CH_PIN2) || (in_sel_d == sar_adc_pkg::CH_TEMP) ||
               (in_sel_d == sar_adc_pkg::CH_FREF);
      // Power down in sleep unless an RC conversion runs or may wake
      power_d = on_d && !(sleep_mode && (!use_rc || (!irq_en_d && !busy_d)));
      // Interrupt gated by enable, wakes from sleep
      irq_d  = flag_d && irq_en_d;
      wake_d = irq_d && sleep_mode;
   end

   // Register stage, reset restores every register
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         aw_full_q  <= 1'b0;
         awaddr_q   <= 8'h00;
         w_full_q   <= 1'b0;
         wdata_q    <= 32'h00000000;
         wstrb0_q   <= 1'b0;
         bvalid_q   <= 1'b0;
         bresp_q    <= sar_adc_pkg::RESP_OKAY;
         rvalid_q   <= 1'b0;
         rdata_q    <= 32'h00000000;
         rresp_q    <= sar_adc_pkg::RESP_OKAY;
         state_q    <= sar_adc_pkg::ST_IDLE;
         clk_sel_q  <= sar_adc_pkg::CTRL_RST[7:5];
         in_sel_q   <= sar_adc_pkg::CTRL_RST[4:2];
         busy_q     <= sar_adc_pkg::CTRL_RST[1];
         on_q       <= sar_adc_pkg::CTRL_RST[0];
         result_q   <= sar_adc_pkg::RESULT_RST;
         flag_q     <= 1'b0;
         irq_en_q   <= 1'b0;
         sar_q      <= 8'h00;
         mask_q     <= 8'h00;
         last_q     <= 1'b0;
         bit_ptr_q  <= 3'h7;
         half_cnt_q <= 5'h00;
         dly_q      <= 2'h0;
         dac_q      <= 8'h00;
         conn_q     <= 1'b1;
         power_q    <= 1'b0;
         irq_q      <= 1'b0;
         wake_q     <= 1'b0;
      end else begin
         aw_full_q  <= aw_full_d;
         awaddr_q   <= awaddr_d;
         w_full_q   <= w_full_d;
         wdata_q    <= wdata_d;
         wstrb0_q   <= wstrb0_d;
         bvalid_q   <= bvalid_d;
         bresp_q    <= bresp_d;
         rvalid_q   <= rvalid_d;
         rdata_q    <= rdata_d;
         rresp_q    <= rresp_d;
         state_q    <= state_d;
         clk_sel_q  <= clk_sel_d;
         in_sel_q   <= in_sel_d;
         busy_q     <= busy_d;
         on_q       <= on_d;
         result_q   <= result_d;
         flag_q     <= flag_d;
         irq_en_q   <= irq_en_d;
         sar_q      <= sar_d;
         mask_q     <= mask_d;
         last_q     <= last_d;
         bit_ptr_q  <= bit_ptr_d;
         half_cnt_q <= half_cnt_d;
         dly_q      <= dly_d;
         dac_q      <= dac_d;
         conn_q     <= conn_d;
         power_q    <= power_d;
         irq_q      <= irq_d;
         wake_q     <= wake_d;
      end
   end

   // Analog and interrupt outputs
   assign channel_select    = in_sel_q;
   assign channel_connected = conn_q;
   assign sample_hold       = (state_q == sar_adc_pkg::ST_CONV);
   assign dac_code          = dac_q;
   assign converter_powered = power_q;
   assign conversion_irq    = irq_q;
   assign wake_request      = wake_q;

   // Checks
   busy_when_off_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      !on_q |-> !busy_q && state_q == sar_adc_pkg::ST_IDLE)
      else $error("busy set while converter off");
   done_flag_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      complete |=> flag_q && !busy_q && result_q == $past(final_code))
      else $error("completion did not set flag and result");
   flag_sticky_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      flag_q && !(do_write && wstrb0_q && awaddr_q == sar_adc_pkg::FLAG_OFF) |=> flag_q)
      else $error("flag cleared by hardware");
   abort_no_flag_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      sw_abort && !flag_q |=> !flag_q && !busy_q)
      else $error("abort set the flag");
   rc_delay_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      $rose(state_q == sar_adc_pkg::ST_DELAY) && on_q && !sleep_mode
      |-> (state_q == sar_adc_pkg::ST_DELAY) [*4] ##1 (state_q != sar_adc_pkg::ST_DELAY))
      else $error("RC start delay not four clocks");
   sleep_abort_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      sleep_mode && !use_rc && busy_q && !do_write |=> !busy_q && on_q ##1 !power_q)
      else $error("sleep did not abort conversion");
   start_needs_on_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      state_q == sar_adc_pkg::ST_IDLE && !on_q |=> state_q == sar_adc_pkg::ST_IDLE)
      else $error("conversion started while off");
   irq_gate_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      flag_q && irq_en_q |-> irq_q && wake_q == $past(sleep_mode))
      else $error("interrupt request not raised");
   conv_len_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      complete |-> half_cnt_q == sar_adc_pkg::HALF_TOTAL - 5'h01 && bit_ptr_q == 3'h0)
      else $error("conversion length wrong");

   normal_done_c: cover property (@(posedge core_clk) disable iff (!reset_n) complete);
   sw_abort_c: cover property (@(posedge core_clk) disable iff (!reset_n) sw_abort);
   rc_sleep_done_c: cover property (@(posedge core_clk) disable iff (!reset_n)
      complete && use_rc && sleep_mode);

endmodule // sar_adc_sequencer

// File: analog_model.sv
`timescale 1ns/100ps
module analog_model (
   // Converter side
   input  wire logic [2:0] channel_select,
   input  wire logic       channel_connected,
   input  wire logic [7:0] dac_code,
   // Comparator back to the sequencer
   output logic            comparator_high
);
   logic [7:0] level;  // Held input level, supply-referenced
   // Fixed level per source
   always_comb begin
      case (channel_select)
         3'h0: level = 8'hA5;
         3'h1: level = 8'hFF;
         3'h2: level = 8'h3C;
         3'h6: level = 8'h5A;
         default: level = 8'h80;
      endcase
   end
   // Input at or above trial code, dead when unconnected
   assign comparator_high = channel_connected && (level >= dac_code);
endmodule // analog_model

// File: sar_adc_sequencer_bench.sv
`timescale 1ns/100ps
module sar_adc_sequencer_bench;
   localparam logic [7:0] C = sar_adc_pkg::CTRL_OFF;  // Offset aliases
   localparam logic [7:0] R = sar_adc_pkg::RESULT_OFF;
   localparam logic [7:0] F = sar_adc_pkg::FLAG_OFF;
   localparam logic [7:0] E = sar_adc_pkg::IRQEN_OFF;
   logic        core_clk, reset_n, sleep_mode, rc_q, cmp, conn, hold, pwr, irq, wake;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [7:0]  awaddr, araddr, dac;
   logic [31:0] wdata, rdata, rd;
   logic [1:0]  bresp, rresp, rs;
   logic [2:0]  chsel;
   int          fails, n_checks, i, cnt;
   // Device under test
   sar_adc_sequencer sar_adc_sequencer_i (.core_clk(core_clk), .reset_n(reset_n),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .sleep_mode(sleep_mode),
      .dedicated_rc_clock(rc_q), .channel_select(chsel), .channel_connected(conn),
      .sample_hold(hold), .dac_code(dac), .comparator_high(cmp),
      .converter_powered(pwr), .conversion_irq(irq), .wake_request(wake));
   // Analog far side
   analog_model analog_model_i (.channel_select(chsel), .channel_connected(conn),
      .dac_code(dac), .comparator_high(cmp));
   // Free-running RC clock, one edge per core cycle
   always @(posedge core_clk) rc_q <= reset_n ? ~rc_q : 1'b0;
   // Clock
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   // Verdict and end of run
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Compare seen against expected
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         fails++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // Hang cut short
   task automatic hang;
      fails++;
      report_and_stop;
   endtask
   // Bus write, both halves offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      logic ta, tw, tb;
      tb = 1'b0;
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      for (n = 0; !tb; n++) begin
         if (n > 50) hang;
         @(negedge core_clk);
         ta = awvalid && awready; tw = wvalid && wready; tb = bvalid;
         @(posedge core_clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end
   endtask
   // Bus read into rd and rs
   task automatic rdr(input logic [7:0] a);
      int n;
      logic tr, ta;
      tr = 1'b0;
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      for (n = 0; !tr; n++) begin
         if (n > 50) hang;
         @(negedge core_clk);
         ta = arvalid && arready;
         tr = rvalid; rd = rdata; rs = rresp;
         @(posedge core_clk);
         if (ta) arvalid <= 1'b0;
      end
   endtask
   // Poll busy until it reads zero
   task automatic wait_idle;
      for (int n = 0; n < 3000; n++) begin
         rdr(C);
         if (rd[1] === 1'b0) return;
      end
      hang;
   endtask
   // Enable, then start in a later write
   task automatic start(input logic [7:0] c);
      wr(C, {24'h0, c | 8'h01});
      repeat (4) @(posedge core_clk);
      wr(C, {24'h0, c | 8'h03});
   endtask
   // Reset values and unmapped read
   task automatic t_reset;
      rdr(C); chk(rd, 32'h0);
      rdr(R); chk(rd, 32'h0);
      rdr(8'h10); chk(rs, sar_adc_pkg::RESP_SLVERR);
      wr(8'h10, 32'h0); chk(bresp, sar_adc_pkg::RESP_SLVERR);
      $display("reset test done");
   endtask
   // Every input select code
   task automatic t_select;
      for (i = 0; i < 8; i++) begin
         wr(C, i << 2);
         chk(chsel, i);
         chk(conn, (i <= 2) || (i >= 6));
      end
      wr(C, 32'h3);
      chk(bresp, sar_adc_pkg::RESP_OKAY);
      rdr(C); chk(rd[1], 1'b0);
      chk(pwr, 1'b1);
      $display("select test done");
   endtask
   // Each divider code: result, duration, flag without irq
   task automatic t_conv;
      logic [2:0] code [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
      for (i = 0; i < 6; i++) begin
         start({code[i], 5'h00});
         for (cnt = 0; cnt < 700; cnt++) begin
            @(negedge core_clk);
            if (hold !== 1'b1) break;
         end
         @(posedge core_clk);
         chk((cnt >= 19 * (1 << i) - 4) && (cnt <= 19 * (1 << i) + 2), 1'b1);
         wait_idle;
         rdr(R); chk(rd, 32'hA5);
         rdr(F); chk(rd, 32'h1);
         chk(irq, 1'b0);
         wr(F, 32'h0);
      end
      $display("conversion test done");
   endtask
   // Interrupt raise, flag persistence, clear, abort
   task automatic t_irq_abort;
      wr(E, 32'h1);
      start(8'h08);
      wait_idle;
      repeat (20) @(posedge core_clk);
      chk(irq, 1'b1);
      rdr(F); chk(rd, 32'h1);
      wr(F, 32'h0);
      @(posedge core_clk);
      chk(irq, 1'b0);
      start(8'hC4);
      repeat (400) @(posedge core_clk);
      wr(C, 32'hC5);
      rdr(R); chk(rd, 32'hFF);
      rdr(F); chk(rd, 32'h0);
      $display("irq and abort test done");
   endtask
   // Sleep with divider clock, then with the RC clock
   task automatic t_sleep;
      start(8'hC0);
      sleep_mode <= 1'b1;
      repeat (4) @(posedge core_clk);
      chk(pwr, 1'b0);
      rdr(C); chk(rd[1:0], 2'h1);
      rdr(F); chk(rd, 32'h0);
      sleep_mode <= 1'b0;
      start(8'hF8);
      sleep_mode <= 1'b1;
      for (cnt = 0; cnt < 300; cnt++) begin
         @(negedge core_clk);
         if (wake === 1'b1) break;
      end
      @(posedge core_clk);
      chk(cnt, 32'h16);
      chk(wake, 1'b1);
      sleep_mode <= 1'b0;
      rdr(R); chk(rd, 32'h5A);
      // RC conversion asleep, interrupt off: power drops after completion
      wr(E, 32'h0);
      start(8'hF8);
      sleep_mode <= 1'b1;
      repeat (10) @(posedge core_clk);
      chk(pwr, 1'b1);
      repeat (20) @(posedge core_clk);
      chk(pwr, 1'b0);
      sleep_mode <= 1'b0;
      rdr(C); chk(rd[1:0], 2'h1);
      $display("sleep test done");
   endtask
   // Reset in mid-conversion abandons it and clears the registers
   task automatic t_midreset;
      start(8'hC0);
      repeat (10) @(posedge core_clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk(hold, 1'b0);
      reset_n <= 1'b1;
      @(posedge core_clk);
      rdr(C); chk(rd, 32'h0);
      rdr(F); chk(rd, 32'h0);
      $display("mid-run reset test done");
   endtask
   // Main sequence
   initial begin
      {reset_n, sleep_mode, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, fails, n_checks} = '0;
      repeat (10) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      t_reset;
      t_select;
      t_conv;
      t_irq_abort;
      t_sleep;
      t_midreset;
      report_and_stop;
   end
endmodule // sar_adc_sequencer_bench
